// file: bench/mmd_decoder_chk.sv
// Concurrent checks on the memory map decoder's ports.
`timescale 1ns/1ps
`default_nettype none
module mmd_decoder_chk
	import mmd_pkg::*;
(
	input wire logic        i_mclk,
	input wire logic        i_rst,
	input wire logic        i_prog_req,
	input wire logic        i_prog_external,
	input wire logic        i_rom_secure,
	input wire logic [2:0]  o_prog_tgt,
	input wire logic        o_prog_blocked,
	input wire logic        i_dr_req,
	input wire logic [15:0] i_dr_addr,
	input wire logic        i_dw_req,
	input wire logic [15:0] i_dw_addr,
	input wire logic [2:0]  o_dr_tgt,
	input wire logic [2:0]  o_dw_tgt,
	input wire logic [2:0]  o_sa_bank,
	input wire logic        o_bank_conflict,
	input wire logic        i_io_req,
	input wire logic [15:0] i_io_addr,
	input wire logic        o_io_alias,
	input wire logic [3:0]  o_io_port,
	input wire logic        i_ready,
	input wire logic        o_global_bus_request,
	input wire logic        o_stall
);
	// Banks are 2K steps above the single RAM base.
	wire logic [15:0] r_off = i_dr_addr - MMD_SA_BASE;
	wire logic [15:0] w_off = i_dw_addr - MMD_SA_BASE;
	wire logic        r_sa = i_dr_req && i_dr_addr >= MMD_SA_BASE && i_dr_addr <= MMD_SA_LAST;
	wire logic        w_sa = i_dw_req && i_dw_addr >= MMD_SA_BASE && i_dw_addr <= MMD_SA_LAST;
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (i_rst);
	property p_mmr;
		i_dr_req && i_dr_addr <= MMD_MMR_LAST |-> o_dr_tgt == MMD_TGT_MMR; endproperty
	a_mmr: assert property (p_mmr) else $error("register window missed");
	property p_bank;
		r_sa |-> o_dr_tgt == MMD_TGT_SA && o_sa_bank == r_off[13:11]; endproperty
	a_bank: assert property (p_bank) else $error("wrong single ram bank");
	property p_conf;
		r_sa && w_sa |-> o_bank_conflict == (r_off[13:11] == w_off[13:11]); endproperty
	a_conf: assert property (p_conf) else $error("bank conflict wrong");
	property p_da;
		i_dr_req && (i_dr_addr inside {[MMD_B2_BASE:MMD_B2_LAST], [MMD_B1_BASE:MMD_B1_LAST]})
			|-> o_dr_tgt == MMD_TGT_DA; endproperty
	a_da: assert property (p_da) else $error("dual ram block missed");
	property p_glb;
		o_global_bus_request |-> (i_dr_req && o_dr_tgt == MMD_TGT_GLB) ||
			(i_dw_req && o_dw_tgt == MMD_TGT_GLB); endproperty
	a_glb: assert property (p_glb) else $error("request without global access");
	property p_stall;
		i_dr_req && o_dr_tgt == MMD_TGT_GLB && !i_ready |-> o_stall && o_global_bus_request;
	endproperty
	a_stall: assert property (p_stall) else $error("global access not held");
	property p_blk;
		i_prog_req && i_prog_external && i_rom_secure && o_prog_tgt == MMD_TGT_ROM
			|-> o_prog_blocked; endproperty
	a_blk: assert property (p_blk) else $error("secure rom fetch not blocked");
	property p_io;
		i_io_req && i_io_addr[15:4] == 12'h000
			&& !(i_dr_req && i_dr_addr inside {[MMD_IOWIN_BASE:MMD_IOWIN_LAST]})
			|-> o_io_alias && o_io_port == i_io_addr[3:0];
	endproperty
	a_io: assert property (p_io) else $error("port alias wrong");
	property p_iow;
		i_dr_req && i_dr_addr inside {[MMD_IOWIN_BASE:MMD_IOWIN_LAST]}
			|-> o_io_alias && o_io_port == i_dr_addr[3:0]; endproperty
	a_iow: assert property (p_iow) else $error("window alias wrong");
	c_glb: cover property (o_stall ##1 !o_stall);
	c_conf: cover property (o_bank_conflict);
	c_alias: cover property (o_io_alias);
endmodule
`default_nettype wire

// file: bench/mmd_far_model.sv
// Far-side model: global arbiter, boot source memory and serial byte source.
`timescale 1ns/1ps
`default_nettype none
module mmd_far_model (
	input  wire logic        i_mclk,
	input  wire logic        i_rst,
	input  wire logic        i_request, // Global bus request from the decoder.
	input  wire logic [3:0]  i_wait,    // Arbitration plus access cycles.
	input  wire logic        i_rd,
	input  wire logic [15:0] i_raddr,
	input  wire logic        i_ser_go,  // Starts one two-byte serial frame.
	output logic             o_ready,
	output logic      [15:0] o_rdata,
	output logic             o_ser_valid,
	output logic      [7:0]  o_ser_byte
);
	logic [3:0]  cnt_q;  // Cycles since the request rose.
	logic [15:0] junk_q; // Moves every cycle so stale data never looks valid.
	logic [2:0]  ser_q;  // Serial frame step; odd steps carry a byte.
	// Ready stays low until arbitration and the access are done.
	assign o_ready = (cnt_q >= i_wait);
	// Data is only meaningful while it is being read.
	assign o_rdata = i_rd ? ~i_raddr : junk_q;
	// High byte goes first, with an idle cycle between the two bytes.
	assign o_ser_valid = ser_q[0];
	assign o_ser_byte = (ser_q == 3'h1) ? 8'hA5 : (ser_q == 3'h3) ? 8'h3C : junk_q[7:0];
	// Counters advance on the processor clock only.
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			cnt_q <= 4'h0;
			junk_q <= 16'h0;
			ser_q <= 3'h0;
		end else begin
			cnt_q <= !i_request ? 4'h0 : (cnt_q == 4'hF) ? cnt_q : cnt_q + 4'h1;
			junk_q <= junk_q + 16'h1357;
			ser_q <= i_ser_go ? 3'h1 : (ser_q == 3'h0 || ser_q == 3'h3) ? 3'h0 : ser_q + 3'h1;
		end
	end
endmodule
`default_nettype wire

// file: bench/tb.sv
// Self-checking bench for the memory map decoder.
`timescale 1ns/1ps
`default_nettype none
module tb;
	import mmd_pkg::*;
	logic        i_mclk = 1'b0;
	logic        i_rst = 1'b1;
	logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata;
	logic        pready, pslverr;
	logic        i_rom_select_input = 1'b1, i_rom_secure = 1'b1;
	logic        i_prog_req = 1'b0, i_prog_external = 1'b0;
	logic        i_dr_req = 1'b0, i_dw_req = 1'b0, i_io_req = 1'b0;
	logic [15:0] i_prog_addr = 16'h0, i_dr_addr = 16'h0, i_dw_addr = 16'h0, i_io_addr = 16'h0;
	logic [2:0]  o_prog_tgt, o_dr_tgt, o_dw_tgt, o_sa_bank;
	logic [3:0]  o_io_port;
	logic        o_prog_blocked, o_bank_conflict, o_io_alias, o_global_bus_request, o_stall;
	logic        i_ready, i_ser_valid, o_boot_rd, o_boot_wr, o_boot_jump;
	logic [7:0]  i_ser_byte;
	logic [15:0] i_boot_rdata, o_boot_raddr, o_boot_waddr, o_boot_wdata, o_boot_entry;
	logic [3:0]  arb_wait = 4'h0; // Arbiter delay used by the far side.
	logic        ser_go = 1'b0;
	int          mismatches = 0, tests_run = 0, cyc = 0;
	// Address map probes and the target each must decode to.
	logic [15:0] da [9] = '{16'h0000, 16'h005F, 16'h0060, 16'h007F, 16'h0300, 16'h04FF,
		16'h0800, 16'h2BFF, 16'h2C00};
	logic [2:0]  dtg [9] = '{MMD_TGT_MMR, MMD_TGT_MMR, MMD_TGT_DA, MMD_TGT_DA, MMD_TGT_DA,
		MMD_TGT_DA, MMD_TGT_SA, MMD_TGT_SA, MMD_TGT_EXT};
	always #4 i_mclk = ~i_mclk;
	mmd_decoder uut (.*);
	mmd_far_model far (.i_mclk(i_mclk), .i_rst(i_rst), .i_request(o_global_bus_request),
		.i_wait(arb_wait), .i_rd(o_boot_rd), .i_raddr(o_boot_raddr), .i_ser_go(ser_go),
		.o_ready(i_ready), .o_rdata(i_boot_rdata), .o_ser_valid(i_ser_valid),
		.o_ser_byte(i_ser_byte));
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e) begin
			mismatches++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic end_sim();
		if (mismatches == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// One APB transfer; the request holds until pready is seen high.
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		@(posedge i_mclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge i_mclk);
		penable <= 1'b1;
		do @(posedge i_mclk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		apb(1'b1, a, d, r, e);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic xe);
		logic [31:0] r;
		logic        e;
		apb(1'b0, a, 32'h0, r, e);
		chk(r, x);
		chk(e, xe);
	endtask
	// Decode inputs move after a rising edge and are judged at the falling one.
	task automatic dt(input logic [15:0] a, input logic [2:0] t);
		@(posedge i_mclk);
		i_dr_req <= 1'b1;
		i_dr_addr <= a;
		@(negedge i_mclk);
		chk(o_dr_tgt, t);
	endtask
	task automatic pair(input logic [15:0] ra, input logic [15:0] wa);
		@(posedge i_mclk);
		i_dr_req <= 1'b1;
		i_dr_addr <= ra;
		i_dw_req <= 1'b1;
		i_dw_addr <= wa;
		@(negedge i_mclk);
	endtask
	task automatic pf(input logic [15:0] a, input logic x);
		@(posedge i_mclk);
		i_prog_req <= 1'b1;
		i_prog_addr <= a;
		i_prog_external <= x;
		@(negedge i_mclk);
	endtask
	task automatic io(input logic [15:0] a);
		@(posedge i_mclk);
		i_io_req <= 1'b1;
		i_io_addr <= a;
		@(negedge i_mclk);
	endtask
	// Bounded wait for the next boot write (0) or jump (1) pulse.
	task automatic wpulse(input int s);
		int n;
		n = 0;
		do begin
			@(negedge i_mclk);
			n++;
		end while ((s == 0 ? o_boot_wr : o_boot_jump) !== 1'b1 && n < 80);
		chk(s == 0 ? o_boot_wr : o_boot_jump, 1'b1);
	endtask
	// A hang counts against the run and closes it.
	always @(posedge i_mclk) begin
		cyc++;
		if (cyc == 5000) begin
			mismatches++;
			end_sim();
		end
	end
	initial begin
		logic [31:0] r;
		logic        e;
		repeat (5) @(posedge i_mclk);
		i_rst <= 1'b0;
		rd(MMD_OFF_GLOBAL_SIZE, 32'h0, 1'b0);
		rd(12'h014, 32'h0, 1'b1);
		rd(MMD_OFF_MODE, 32'h1, 1'b0);
		pf(16'h0100, 1'b1);
		chk(o_prog_blocked, 1'b1);
		pf(16'h0100, 1'b0);
		chk({o_prog_blocked, o_prog_tgt}, {1'b0, MMD_TGT_ROM});
		wr(MMD_OFF_MODE, 32'h2);
		pf(16'h0100, 1'b0);
		chk(o_prog_tgt, MMD_TGT_EXT);
		pf(16'hFE00, 1'b0);
		chk(o_prog_tgt, MMD_TGT_DA);
		wr(MMD_OFF_MODE, 32'h0);
		pf(16'hFE00, 1'b0);
		chk(o_prog_tgt, MMD_TGT_EXT);
		dt(16'h02FF, MMD_TGT_DA);
		foreach (da[i]) dt(da[i], dtg[i]);
		pair(16'h2800, 16'h2BFF);
		chk({o_sa_bank, o_bank_conflict}, {3'h4, 1'b1});
		pair(16'h2800, 16'h2000);
		chk({o_sa_bank, o_bank_conflict}, {3'h4, 1'b0});
		pair(16'h0300, 16'h0300);
		chk({o_dr_tgt, o_dw_tgt, o_bank_conflict}, {MMD_TGT_DA, MMD_TGT_DA, 1'b0});
		arb_wait <= 4'h3;
		wr(MMD_OFF_GLOBAL_SIZE, 32'h80);
		pair(16'h8000, 16'h0300);
		chk({o_dr_tgt, o_global_bus_request, o_stall}, {MMD_TGT_GLB, 2'b11});
		repeat (3) @(negedge i_mclk);
		chk({o_global_bus_request, o_stall}, 2'b10);
		dt(16'h7FFF, MMD_TGT_EXT);
		wr(MMD_OFF_GLOBAL_SIZE, 32'hFF);
		dt(16'hFF00, MMD_TGT_GLB);
		dt(16'hFEFF, MMD_TGT_EXT);
		@(posedge i_mclk);
		i_dr_req <= 1'b0;
		i_dw_req <= 1'b0;
		io(16'h0003);
		chk({o_io_alias, o_io_port}, {1'b1, 4'h3});
		io(16'hFFF3);
		chk(o_io_alias, 1'b0);
		wr(MMD_OFF_BOOT_LEN, 32'h2);
		wr(MMD_OFF_BOOT_CTRL, 32'h401);
		for (int k = 0; k < 2; k++) begin
			wpulse(0);
			chk({o_boot_wdata, o_boot_waddr}, {16'(~(16'h0400 + 16'(k))), 16'(k)});
		end
		wpulse(1);
		chk(o_boot_entry, 16'h0);
		apb(1'b0, MMD_OFF_BOOT_CTRL, 32'h0, r, e);
		chk(r[0], 1'b0);
		wr(MMD_OFF_BOOT_LEN, 32'h1);
		wr(MMD_OFF_BOOT_CTRL, 32'h7);
		@(posedge i_mclk);
		ser_go <= 1'b1;
		@(posedge i_mclk);
		ser_go <= 1'b0;
		wpulse(0);
		chk(o_boot_wdata, 16'hA53C);
		wpulse(1);
		wr(MMD_OFF_BOOT_CTRL, 32'h805);
		wpulse(0);
		chk({o_boot_wdata, o_boot_waddr}, {16'hFFFE, 16'h0000});
		wpulse(1);
		end_sim();
	end
endmodule
bind mmd_decoder mmd_decoder_chk chk_i (.*);
`default_nettype wire

// file: rtl/mmd_decoder.sv
// Memory map decoder with global arbitration, ROM control, banks and boot copy.
`timescale 1ns/1ps
`default_nettype none
module mmd_decoder (
	input  wire logic                 i_mclk,          // Processor clock.
	input  wire logic                 i_rst,           // Asynchronous reset.
	// APB slave.
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire logic                 pwrite,
	input  wire logic [11:0]          paddr,
	input  wire logic [31:0]          pwdata,
	output logic      [31:0]          prdata,
	output logic                      pready,
	output logic                      pslverr,
	// Straps and security.
	input  wire logic                 i_rom_select_input, // High enables ROM.
	input  wire logic                 i_rom_secure,       // Security option.
	// Program port (fetch).
	input  wire logic                 i_prog_req,
	input  wire logic [15:0]          i_prog_addr,
	input  wire logic                 i_prog_external,    // Fetch from off chip.
	output logic      [2:0]           o_prog_tgt,
	output logic                      o_prog_blocked,
	// Data ports: read, write, and the I/O port.
	input  wire logic                 i_dr_req,
	input  wire logic [15:0]          i_dr_addr,
	input  wire logic                 i_dw_req,
	input  wire logic [15:0]          i_dw_addr,
	input  wire logic                 i_io_req,
	input  wire logic [15:0]          i_io_addr,
	output logic      [2:0]           o_dr_tgt,
	output logic      [2:0]           o_dw_tgt,
	output logic      [2:0]           o_sa_bank,        // Bank of data read.
	output logic                      o_bank_conflict,
	output logic                      o_io_alias,
	output logic      [3:0]           o_io_port,
	// External bus handshake.
	input  wire logic                 i_ready,
	output logic                      o_global_bus_request,
	output logic                      o_stall,
	// Boot copy engine program-write and serial source.
	input  wire logic                 i_ser_valid,
	input  wire logic [7:0]           i_ser_byte,
	input  wire logic [15:0]          i_boot_rdata,
	output logic                      o_boot_rd,
	output logic      [15:0]          o_boot_raddr,
	output logic                      o_boot_wr,
	output logic      [15:0]          o_boot_waddr,
	output logic      [15:0]          o_boot_wdata,
	output logic                      o_boot_jump,
	output logic      [15:0]          o_boot_entry
);
	import mmd_pkg::*;

	// ----------------------------------------------------------------------
	// Software-visible registers and internal state.
	// ----------------------------------------------------------------------
	logic [7:0]  global_size_reg_q;          // Global size register.
	logic        rom_en_q;        // ROM enable, captured at reset release.
	logic        strap_done_q;    // Set after the strap was caught.
	logic        cnf_q;           // Block zero space flag.
	logic [15:0] boot_ctrl_q;     // Boot control.
	logic [15:0] boot_len_q;      // Boot word count.
	mmd_boot_t   bt_q;            // Boot state.
	logic [15:0] bt_cnt_q;        // Words copied.
	logic [15:0] bt_src_q;        // Source pointer.
	logic        bt_hi_q;         // High byte held when byte-wide.
	logic [7:0]  bt_byte_q;       // First byte of a pair.
	logic        glb_pend_q;      // Global access in progress.

	// ----------------------------------------------------------------------
	// Global mask from the size register.
	// ----------------------------------------------------------------------
	// Each bit of the size register reserves one more upper address bit. Only
	// the contiguous run from the top counts, so a stray low bit cannot punch
	// holes into the map.
	logic [15:0] glb_mask;
	logic        glb_run; // Still inside the run of ones from bit 7.
	always_comb begin
		glb_mask = 16'h0000;
		glb_run  = 1'b1;
		for (int i = 0; i < 8; i++) begin
			glb_run        = glb_run && global_size_reg_q[7-i];
			glb_mask[15-i] = glb_run;
		end
	end

	// Decode of one data address into a target. The order of the tests is the
	// priority: the global region is checked first so that a large global size
	// can take over the whole upper half, while the register window, the dual
	// RAM blocks and the single RAM all sit below it. An address that hits
	// nothing on chip falls through to the external data bus.
	function automatic logic [2:0] dec_data(input logic [15:0] a, input logic [15:0] m,
		input logic block0_space_flag);
		logic [2:0] t;
		t = MMD_TGT_EXT;
		if (m != 16'h0000 && (a & m) == m) begin
			t = MMD_TGT_GLB;
		end else if (a <= MMD_MMR_LAST) begin
			t = MMD_TGT_MMR;
		end else if (a >= MMD_B2_BASE && a <= MMD_B2_LAST) begin
			t = MMD_TGT_DA;
		end else if (a >= MMD_B1_BASE && a <= MMD_B1_LAST) begin
			t = MMD_TGT_DA;
		end else if (!block0_space_flag && a >= MMD_B0_BASE && a <= MMD_B0_LAST) begin
			t = MMD_TGT_DA;
		end else if (a >= MMD_SA_BASE && a <= MMD_SA_LAST) begin
			t = MMD_TGT_SA;
		end
		return t;
	endfunction

	// Bank index of a single RAM address; the last bank is the 1K remainder.
	// The index means nothing outside single RAM, so the conflict logic
	// below qualifies it with the decoded target first.
	function automatic logic [2:0] sa_bank(input logic [15:0] a);
		logic [15:0] off;
		off = a - MMD_SA_BASE;
		return off[13:11];
	endfunction

	// ----------------------------------------------------------------------
	// Continuous decode of the four ports.
	// ----------------------------------------------------------------------
	wire [2:0] dr_tgt = dec_data(i_dr_addr, glb_mask, cnf_q);
	wire [2:0] dw_tgt = dec_data(i_dw_addr, glb_mask, cnf_q);
	wire       rom_hit = rom_en_q && i_prog_addr <= MMD_ROM_LAST;
	wire       b0p_hit = cnf_q && i_prog_addr >= MMD_B0P_BASE;
	wire       prog_block = rom_hit && i_prog_external && i_rom_secure;
	wire       dr_sa = i_dr_req && dr_tgt == MMD_TGT_SA;
	wire       dw_sa = i_dw_req && dw_tgt == MMD_TGT_SA;
	// Dual RAM serves read and write at once; only same-bank single RAM clashes.
	wire       conflict = dr_sa && dw_sa && sa_bank(i_dr_addr) == sa_bank(i_dw_addr);
	wire       io_win = i_dr_req && i_dr_addr >= MMD_IOWIN_BASE
		&& i_dr_addr <= MMD_IOWIN_LAST;
	wire       glb_now = (i_dr_req && dr_tgt == MMD_TGT_GLB)
		|| (i_dw_req && dw_tgt == MMD_TGT_GLB);
	wire       ext_now = (i_dr_req && dr_tgt == MMD_TGT_EXT)
		|| (i_dw_req && dw_tgt == MMD_TGT_EXT)
		|| (i_prog_req && !rom_hit && !b0p_hit)
		|| i_io_req;

	assign o_dr_tgt  = dr_tgt;
	assign o_dw_tgt  = dw_tgt;
	assign o_sa_bank = sa_bank(i_dr_addr);
	assign o_bank_conflict = conflict;
	assign o_prog_tgt = rom_hit ? MMD_TGT_ROM : (b0p_hit ? MMD_TGT_DA : MMD_TGT_EXT);
	assign o_prog_blocked = prog_block;
	// The alias works from both sides: window reads and short I/O ports.
	assign o_io_alias = io_win || (i_io_req && i_io_addr[15:4] == 12'h000);
	assign o_io_port  = io_win ? i_dr_addr[3:0] : i_io_addr[3:0];
	// Request is raised in the first cycle of a global access and kept while the port presents it, also after ready.
	assign o_global_bus_request = glb_now;
	// On-chip data and program targets never wait; every I/O access, global and external ones hold until the party answers.
	assign o_stall = (glb_now || ext_now) && !i_ready;

	// Global access tracker: registered marker of a global access waiting on ready, used for status.
	// It only feeds the status register; the request itself stays purely
	// combinational so the arbiter sees it in the first cycle of the access.
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			glb_pend_q <= 1'b0;
		end else begin
			glb_pend_q <= glb_now && !i_ready;
		end
	end

	// ----------------------------------------------------------------------
	// APB slave: zero wait, unmapped reads zero with error.
	// ----------------------------------------------------------------------
	// The slave never stretches a transfer, so pready is tied high. Any offset
	// outside the five registers answers with pslverr in the access phase and
	// leaves all state untouched.
	wire        acc      = psel && penable;
	wire        wr       = acc && pwrite;
	wire        hit_global_size_reg = paddr == MMD_OFF_GLOBAL_SIZE;
	wire        hit_mode = paddr == MMD_OFF_MODE;
	wire        hit_bctl = paddr == MMD_OFF_BOOT_CTRL;
	wire        hit_blen = paddr == MMD_OFF_BOOT_LEN;
	wire        hit_stat = paddr == MMD_OFF_STATUS;
	wire        mapped   = hit_global_size_reg | hit_mode | hit_bctl | hit_blen | hit_stat;
	wire [31:0] rd_mux   =
		hit_global_size_reg ? {24'h000000, global_size_reg_q} :
		hit_mode ? {30'h00000000, cnf_q, rom_en_q} :
		hit_bctl ? {16'h0000, boot_ctrl_q} :
		hit_blen ? {16'h0000, boot_len_q} :
		hit_stat ? {23'h000000, glb_pend_q, bt_q, bt_cnt_q[3:0]} : 32'h00000000;
	assign pready  = 1'b1;
	assign pslverr = acc && !mapped;

	// Read data register, loaded during setup so it stands in the access phase.
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			prdata <= 32'h00000000;
		end else if (psel && !penable && !pwrite) begin
			prdata <= rd_mux;
		end
	end

	// The strap is read at the first edge after reset rather than during it,
	// which keeps the reset branch free of anything but constants. Software
	// writes to the mode register take over from the second edge on.
	// Configuration registers; the ROM strap is caught once after reset.
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			global_size_reg_q       <= MMD_GLOBAL_SIZE_REG_RST;
			rom_en_q     <= 1'b0;
			strap_done_q <= 1'b0;
			cnf_q        <= 1'b0;
			boot_len_q   <= MMD_LEN_RST;
		end else begin
			strap_done_q <= 1'b1;
			if (!strap_done_q) begin
				rom_en_q <= i_rom_select_input;
			end else if (wr && hit_mode) begin
				rom_en_q <= pwdata[MMD_MODE_ROM_BIT];
			end
			if (wr && hit_mode) begin
				cnf_q <= pwdata[MMD_MODE_CNF_BIT];
			end
			if (wr && hit_global_size_reg) begin
				global_size_reg_q <= pwdata[7:0];
			end
			if (wr && hit_blen) begin
				boot_len_q <= pwdata[15:0];
			end
		end
	end

	// ----------------------------------------------------------------------
	// Boot copy engine.
	// ----------------------------------------------------------------------
	wire bt_ser  = boot_ctrl_q[MMD_BOOT_SER_BIT];
	wire bt_byte = boot_ctrl_q[MMD_BOOT_BYTE_BIT];
	// A serial source always arrives byte by byte and pairs high then low.
	wire src_ok  = bt_ser ? i_ser_valid : 1'b1;
	wire [7:0] src_byte = bt_ser ? i_ser_byte : i_boot_rdata[7:0];
	wire pair_done = (bt_byte || bt_ser) ? bt_hi_q : 1'b1;
	wire [15:0] word_out = (bt_byte || bt_ser) ? {bt_byte_q, src_byte} : i_boot_rdata;

	// Limitation: a data-memory source is read with no wait states, so it must
	// live in on-chip RAM. A serial source ignores the base field. Writing the
	// control register during a copy changes the mode bits at once, so
	// software should wait for the jump pulse before starting another copy.
	// Copy sequencer: one source item per read beat, one program write per word.
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			bt_q        <= MMD_BT_IDLE;
			boot_ctrl_q <= 16'h0000;
			bt_cnt_q    <= 16'h0000;
			bt_src_q    <= 16'h0000;
			bt_hi_q     <= 1'b0;
			bt_byte_q   <= 8'h00;
			o_boot_wr   <= 1'b0;
			o_boot_waddr <= 16'h0000;
			o_boot_wdata <= 16'h0000;
			o_boot_jump <= 1'b0;
		end else begin
			o_boot_wr   <= 1'b0;
			o_boot_jump <= 1'b0;
			if (wr && hit_bctl) begin
				boot_ctrl_q <= pwdata[15:0];
			end
			case (bt_q)
				MMD_BT_IDLE: begin
					if (wr && hit_bctl && pwdata[MMD_BOOT_GO_BIT]) begin
						// Source base is forced onto a 1K-word boundary.
						bt_src_q <= {pwdata[15:MMD_BOOT_BASE_LSB], 10'h000};
						bt_cnt_q <= 16'h0000;
						bt_hi_q  <= 1'b0;
						bt_q     <= MMD_BT_READ;
					end
				end
				MMD_BT_READ: begin
					if (bt_cnt_q == boot_len_q) begin
						bt_q <= MMD_BT_DONE;
					end else if (src_ok) begin
						bt_src_q <= bt_src_q + 16'h0001;
						if (pair_done) begin
							o_boot_wr    <= 1'b1;
							o_boot_waddr <= bt_cnt_q;
							o_boot_wdata <= word_out;
							bt_hi_q      <= 1'b0;
							bt_q         <= MMD_BT_WRT;
						end else begin
							bt_byte_q <= src_byte;
							bt_hi_q   <= 1'b1;
						end
					end
				end
				MMD_BT_WRT: begin
					bt_cnt_q <= bt_cnt_q + 16'h0001;
					bt_q     <= MMD_BT_READ;
				end
				MMD_BT_DONE: begin
					o_boot_jump <= 1'b1;
					boot_ctrl_q[MMD_BOOT_GO_BIT] <= 1'b0;
					bt_q <= MMD_BT_IDLE;
				end
				default: begin
					bt_q <= MMD_BT_IDLE;
				end
			endcase
		end
	end

	assign o_boot_rd    = bt_q == MMD_BT_READ && !bt_ser && bt_cnt_q != boot_len_q;
	assign o_boot_raddr = bt_src_q;
	assign o_boot_entry = 16'h0000; // Program is copied to address zero.

endmodule
`default_nettype wire

// file: rtl/mmd_pkg.sv
// Package of constants and types for the signal processor memory map decoder.
// Operation
// - Decode program, data and I/O 64K spaces
// - Top data region sized by global size
// - Global accesses arbitrated through bus request
// - Assert bus request at each global access start
// - Data 0 to 5F map to registers
// - Lowest 16 I/O ports aliased in window; the code aliases window reads only, not writes
// - Two-word I/O reaches whole I/O space
// - ROM enable sampled at reset, software changeable
// - Enabled ROM at low program, else external
// - Security blocks external fetches reading ROM
// - Boot copies from data or serial port
// - Boot hands execution to copied program
// - Single RAM in independent 2K blocks
// - One smaller block holds the remainder
// - Banking follows the variant configuration
// - Dual RAM takes read and write together
// - Block one 512 words, block two 32
// - Block zero moves between data and program
// - On-chip zero wait, external waits on ready; the code also holds aliased I/O ports 0 to F on ready
// - Up to three accesses per cycle
package mmd_pkg;

	// ----------------------------------------------------------------------
	// Register map on the APB slave (byte addresses).
	// ----------------------------------------------------------------------
	localparam logic [11:0] MMD_OFF_GLOBAL_SIZE = 12'h000; // Global size register.
	localparam logic [11:0] MMD_OFF_MODE        = 12'h004; // Processor mode status.
	localparam logic [11:0] MMD_OFF_BOOT_CTRL   = 12'h008; // Boot source and base.
	localparam logic [11:0] MMD_OFF_BOOT_LEN    = 12'h00C; // Boot word count.
	localparam logic [11:0] MMD_OFF_STATUS      = 12'h010; // Decoder status.

	// ----------------------------------------------------------------------
	// Field positions and reset values.
	// ----------------------------------------------------------------------
	localparam int MMD_MODE_ROM_BIT  = 0; // ROM enable bit in mode register.
	localparam int MMD_MODE_CNF_BIT  = 1; // Block zero space flag.
	localparam int MMD_BOOT_GO_BIT   = 0; // Boot start bit.
	localparam int MMD_BOOT_SER_BIT  = 1; // Serial port source when set.
	localparam int MMD_BOOT_BYTE_BIT = 2; // Byte-wide source when set.
	localparam int MMD_BOOT_BASE_LSB = 10; // Source base on 1K boundary.
	localparam logic [7:0]  MMD_GLOBAL_SIZE_REG_RST = 8'h00; // No global memory at reset.
	localparam logic [15:0] MMD_LEN_RST  = 16'h0000;

	// ----------------------------------------------------------------------
	// Address map figures.
	// ----------------------------------------------------------------------
	localparam logic [15:0] MMD_MMR_LAST   = 16'h005F; // Last mapped register.
	localparam logic [15:0] MMD_IOWIN_BASE = 16'h0050; // Port alias base.
	localparam logic [15:0] MMD_IOWIN_LAST = 16'h005F; // Port alias end, 16 ports.
	localparam logic [15:0] MMD_ROM_LAST   = 16'h07FF; // ROM top, 2K words.
	localparam logic [15:0] MMD_B2_BASE    = 16'h0060; // Block two, 32 words.
	localparam logic [15:0] MMD_B2_LAST    = 16'h007F;
	localparam logic [15:0] MMD_B0_BASE    = 16'h0100; // Block zero in data space.
	localparam logic [15:0] MMD_B0_LAST    = 16'h02FF;
	localparam logic [15:0] MMD_B1_BASE    = 16'h0300; // Block one, 512 words.
	localparam logic [15:0] MMD_B1_LAST    = 16'h04FF;
	localparam logic [15:0] MMD_B0P_BASE   = 16'hFE00; // Block zero in program.
	localparam logic [15:0] MMD_SA_BASE    = 16'h0800; // Single RAM base.
	localparam logic [15:0] MMD_SA_LAST    = 16'h2BFF; // Four 2K plus one 1K.
	localparam int MMD_SA_BLOCKS = 5; // Block count of this variant.

	// ----------------------------------------------------------------------
	// Target encodings.
	// ----------------------------------------------------------------------
	typedef enum logic [2:0] {
		MMD_TGT_EXT = 3'h0,
		MMD_TGT_MMR = 3'h1,
		MMD_TGT_ROM = 3'h2,
		MMD_TGT_SA  = 3'h3,
		MMD_TGT_DA  = 3'h4,
		MMD_TGT_GLB = 3'h5
	} mmd_tgt_t;

	// Boot state machine, one-hot.
	typedef enum logic [3:0] {
		MMD_BT_IDLE = 4'h1,
		MMD_BT_READ = 4'h2,
		MMD_BT_WRT  = 4'h4,
		MMD_BT_DONE = 4'h8
	} mmd_boot_t;

endpackage
